// file: common/wss_pkg.sv
// Purpose: Shared constants for the word-serial servant port
// Assumes: A16/D16 backplane slave, 125 MHz sys_clk
// Notes: Offsets are byte offsets inside the 64-byte block
// Summary of operation
// - Answer only A16 D16 slave accesses
// - D16 interrupter, status word on acknowledge
// - Fast-handshake stall raises bus error
// - Handshake bits always track interface state
// - Block base is address*40H plus C000H
// - Never master; no signal register
// - Read-only response register at 000AH
// - Offset 0004H status read, control write
// - Protocol register always reads F7FFh
// - Read-protocol command answers F62Bh
// - Release string only after its terminator
// - Semicolon separates commands
// - Twenty queued strings; extra strings discarded
// - Letters matched regardless of case
// - Bytes 00-09, 0B-20 are white space
// - Every response ends with line feed
// - Read without pending query times out
package wss_pkg;
    localparam logic [5:0] OFF_MAKER = 6'h00;
    localparam logic [5:0] OFF_KIND = 6'h02;
    localparam logic [5:0] OFF_STAT = 6'h04;
    localparam logic [5:0] OFF_SPARE = 6'h06;
    localparam logic [5:0] OFF_PROTO = 6'h08;
    localparam logic [5:0] OFF_RESP = 6'h0a;
    localparam logic [5:0] OFF_DHI = 6'h0c;
    localparam logic [5:0] OFF_DLO = 6'h0e;
    localparam logic [5:0] AM_A16_USER = 6'h29;
    localparam logic [5:0] AM_A16_SUPV = 6'h2d;
    localparam logic [1:0] BASE_TOP = 2'h3;
    localparam logic [15:0] PROTO_VAL = 16'hf7ff;
    localparam logic [15:0] RDPROTO_VAL = 16'hf62b;
    localparam logic [15:0] BRQ_WORD = 16'hdeff;
    localparam logic [6:0] BAV_TAG = 7'h5e;
    localparam int END_POS = 8;
    localparam logic [7:0] LF_CHAR = 8'h0a;
    localparam logic [7:0] SEMI_CHAR = 8'h3b;
    localparam logic [7:0] SPACE_CHAR = 8'h20;
    localparam logic [7:0] LOW_A = 8'h61;
    localparam logic [7:0] LOW_Z = 8'h7a;
    localparam logic [7:0] CASE_MASK = 8'hdf;
    localparam logic [7:0] MAX_STR_LEN = 8'hff;
    localparam logic [4:0] MAX_STRINGS = 5'h14;
    localparam logic [8:0] RING_DEPTH = 9'h100;
    localparam int RSP_W = 9;
    localparam int RSP_DEPTH = 16;
    localparam logic [15:0] RESP_FIXED = 16'h49ff;
    localparam int RB_DOR = 13;
    localparam int RB_DIR = 12;
    localparam int RB_RR = 10;
    localparam int RB_WR = 9;
    localparam logic [15:0] STAT_FIXED = 16'hfff3;
    localparam int ST_PASSED = 2;
    localparam int ST_READY = 3;
    localparam int CT_SOFTRST = 0;
    localparam logic [2:0] IRQ_LEVEL = 3'h1;
    localparam int CLK_PERIOD_NS = 8;
    localparam int FHS_WAIT_NS = 100;
    localparam int FHS_WAIT_CYC = FHS_WAIT_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_ACK, S_BERR, S_IGNORE} slave_state_t;
endpackage

// file: src/pin_sync.sv
// Purpose: Two-flop synchroniser for backplane pins
// Assumes: Inputs are asynchronous to sys_clk
// Notes: Resets to all ones so strobes read idle
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r <= '1;
            dout <= '1;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// file: src/resp_fifo.sv
// Purpose: Response byte FIFO between processor and data register
// Assumes: Single clock, DEPTH a power of two
// Notes: Flush drops all entries in one cycle
module resp_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [0:DEPTH-1];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;

    assign in_ready = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
    assign out_valid = wr_r != rd_r;
    assign out_data = mem_r[rd_r[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (in_valid && in_ready) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || flush) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_r <= wr_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

// file: src/word_serial_servant_port.sv
// Purpose: Message-based word-serial servant on an A16/D16 backplane
// Assumes: Commander follows the word-serial handshake; sys_clk 125 MHz
// Notes: Address and data are sampled through the same sync delay as strobes
module word_serial_servant_port #(
    parameter logic [15:0] MAKER_ID = 16'hfabc,
    parameter logic [15:0] KIND_ID = 16'hf123,
    parameter logic [15:0] RDPROTO_CMD = 16'hcfff,
    parameter logic [15:0] CLEAR_CMD = 16'hffff
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Backplane address and strobes
    input wire logic [15:1] bus_addr,
    input wire logic [5:0] bus_am,
    input wire logic bus_as_n,
    input wire logic [1:0] bus_ds_n,
    input wire logic bus_write_n,
    input wire logic bus_lword_n,
    input wire logic bus_iack_n,
    input wire logic bus_iackin_n,
    output logic bus_iackout_n,
    // Backplane data and open-drain returns
    input wire logic [15:0] bus_data_i,
    output logic [15:0] bus_data_o,
    output logic bus_data_oe,
    output logic bus_dtack_o,
    output logic bus_dtack_oe,
    output logic bus_berr_o,
    output logic bus_berr_oe,
    output logic bus_irq_o,
    output logic bus_irq_oe,
    // Logical address switches
    input wire logic [7:0] la_switch,
    // Command bytes to the processor
    output logic [7:0] cmd_byte,
    output logic cmd_sep,
    output logic cmd_ws,
    output logic cmd_last,
    output logic cmd_valid,
    input wire logic cmd_ready,
    // Response bytes from the processor
    input wire logic [7:0] rsp_byte,
    input wire logic rsp_last,
    input wire logic rsp_valid,
    output logic rsp_ready,
    // Interrupt request and interface clear
    input wire logic int_req,
    input wire logic [7:0] int_cause,
    output logic iface_clear
);
    import wss_pkg::*;

    logic [51:0] raw;
    logic [51:0] syn;
    logic [15:1] a_s;
    logic [5:0] am_s;
    logic as_n_s;
    logic [1:0] ds_n_s;
    logic wr_n_s;
    logic lw_n_s;
    logic iack_n_s;
    logic iackin_n_s;
    logic [15:0] d_s;
    logic [7:0] la_s;
    slave_state_t st_r;
    logic [15:0] data_o_r;
    logic rd_r;
    logic [3:0] wait_cnt_r;
    logic strobe, ds_idle, hit, my_iack, known_rd, wr_take, dlo_rd_take;
    logic [5:0] off;
    logic [15:0] reg_rd;
    logic [15:0] resp_word;
    logic [15:0] ctrl_r;
    logic brq_pend_r, rr_r;
    logic [15:0] data_low_r;
    logic bav, brq, rdp, clr, clr_all, clr_r;
    logic irq_pend_r, iack_own_r, iackout_n_r;
    logic [7:0] cause_r;
    logic lf_pend_r;
    logic f_in_valid, f_in_ready, f_out_valid, f_pop;
    logic [RSP_W-1:0] f_in_data, f_out_data;
    logic [10:0] ring_r [0:255];
    logic [7:0] wp_r, rp_r, cur_len_r;
    logic [8:0] ring_cnt_r;
    logic [4:0] str_cnt_r;
    logic drop_r, lead_r;
    logic [10:0] head;
    logic term_in, ws_in, sep_in, str_full, q_full, push, avail, skip, pop;
    logic [7:0] up_in;

    // Address and data ride the same two-flop delay as the strobes
    assign raw = {bus_addr, bus_am, bus_as_n, bus_ds_n, bus_write_n, bus_lword_n,
                  bus_iack_n, bus_iackin_n, bus_data_i, la_switch};
    pin_sync #(.W(52)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(raw),
        .dout(syn)
    );
    assign {a_s, am_s, as_n_s, ds_n_s, wr_n_s, lw_n_s, iack_n_s, iackin_n_s, d_s, la_s} = syn;

    // Slave decode
    assign strobe = !as_n_s && (ds_n_s == 2'b00);
    assign ds_idle = ds_n_s == 2'b11;
    assign hit = (am_s == AM_A16_USER || am_s == AM_A16_SUPV) && lw_n_s && iack_n_s
        && a_s[15:14] == BASE_TOP && a_s[13:6] == la_s;
    assign off = {a_s[5:1], 1'b0};
    assign my_iack = !iack_n_s && !iackin_n_s && !as_n_s && irq_pend_r && a_s[3:1] == IRQ_LEVEL;
    assign known_rd = off == OFF_MAKER || off == OFF_KIND || off == OFF_STAT
        || off == OFF_PROTO || off == OFF_RESP || off == OFF_DHI;
    assign wr_take = st_r == S_IDLE && strobe && hit && !wr_n_s;
    assign dlo_rd_take = (st_r == S_IDLE && strobe && hit && wr_n_s && off == OFF_DLO && rr_r)
        || (st_r == S_WAIT && rr_r);

    // Handshake bits follow live state
    always_comb begin
        resp_word = RESP_FIXED;
        resp_word[RB_DOR] = f_out_valid || rr_r;
        resp_word[RB_DIR] = !q_full;
        resp_word[RB_RR] = rr_r;
        resp_word[RB_WR] = !brq_pend_r && !rr_r;
    end

    always_comb begin
        reg_rd = '0;
        if (off == OFF_MAKER) begin
            reg_rd = MAKER_ID;
        end else if (off == OFF_KIND) begin
            reg_rd = KIND_ID;
        end else if (off == OFF_STAT) begin
            reg_rd = STAT_FIXED;
            reg_rd[ST_PASSED] = 1'b1;
            reg_rd[ST_READY] = !ctrl_r[CT_SOFTRST];
        end else if (off == OFF_PROTO) begin
            reg_rd = PROTO_VAL;
        end else if (off == OFF_RESP) begin
            reg_rd = resp_word;
        end
    end

    // Slave cycle sequencer; answers only, never requests the bus
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= S_IDLE;
            data_o_r <= '0;
            rd_r <= 1'b0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (strobe) begin
                        rd_r <= wr_n_s;
                        if (my_iack) begin
                            data_o_r <= {cause_r, la_s};
                            rd_r <= 1'b1;
                            st_r <= S_ACK;
                        end else if (!hit) begin
                            st_r <= S_IGNORE;
                        end else if (wr_n_s && off == OFF_DLO) begin
                            if (rr_r) begin
                                data_o_r <= data_low_r;
                                st_r <= S_ACK;
                            end else if (brq_pend_r) begin
                                st_r <= S_WAIT;
                            end else begin
                                st_r <= S_IGNORE;
                            end
                        end else if (wr_n_s && known_rd) begin
                            data_o_r <= reg_rd;
                            st_r <= S_ACK;
                        end else if (!wr_n_s && (off == OFF_DLO || off == OFF_STAT
                                || off == OFF_SPARE)) begin
                            st_r <= S_ACK;
                        end else begin
                            st_r <= S_IGNORE;
                        end
                    end
                end
                S_WAIT: begin
                    if (ds_idle) begin
                        st_r <= S_IDLE;
                    end else if (rr_r) begin
                        data_o_r <= data_low_r;
                        st_r <= S_ACK;
                    end else if (wait_cnt_r == 4'(FHS_WAIT_CYC - 1)) begin
                        st_r <= S_BERR;
                    end
                end
                default: begin
                    if (ds_idle) begin
                        st_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Fast-handshake patience before raising bus error
    always_ff @(posedge sys_clk) begin
        if (rst || st_r != S_WAIT) begin
            wait_cnt_r <= '0;
        end else begin
            wait_cnt_r <= wait_cnt_r + 4'h1;
        end
    end

    assign bus_dtack_o = 1'b0;
    assign bus_dtack_oe = st_r == S_ACK;
    assign bus_berr_o = 1'b0;
    assign bus_berr_oe = st_r == S_BERR;
    assign bus_data_o = data_o_r;
    assign bus_data_oe = st_r == S_ACK && rd_r;
    assign bus_irq_o = 1'b0;
    assign bus_irq_oe = irq_pend_r;
    assign bus_iackout_n = iackout_n_r;
    assign iface_clear = clr_r;

    // Word-serial commands written to the low data word
    assign bav = wr_take && off == OFF_DLO && d_s[15:9] == BAV_TAG;
    assign brq = wr_take && off == OFF_DLO && d_s == BRQ_WORD;
    assign rdp = wr_take && off == OFF_DLO && d_s == RDPROTO_CMD;
    assign clr = wr_take && off == OFF_DLO && d_s == CLEAR_CMD;
    assign clr_all = clr || ctrl_r[CT_SOFTRST];
    assign f_pop = brq_pend_r && !rr_r && !rdp && f_out_valid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= '0;
        end else if (wr_take && off == OFF_STAT) begin
            ctrl_r <= d_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clr_r <= 1'b0;
        end else begin
            clr_r <= clr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || clr_all) begin
            brq_pend_r <= 1'b0;
        end else if (brq) begin
            brq_pend_r <= 1'b1;
        end else if (f_pop) begin
            brq_pend_r <= 1'b0;
        end
    end

    // Data register: set has no competing clear since it loads only while empty
    always_ff @(posedge sys_clk) begin
        if (rst || clr_all) begin
            rr_r <= 1'b0;
            data_low_r <= '0;
        end else if (dlo_rd_take) begin
            rr_r <= 1'b0;
        end else if (!rr_r && rdp) begin
            rr_r <= 1'b1;
            data_low_r <= RDPROTO_VAL;
        end else if (f_pop) begin
            rr_r <= 1'b1;
            data_low_r <= {7'h00, f_out_data};
        end
    end

    // Interrupter; a new request in the acknowledge cycle is kept
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_pend_r <= 1'b0;
            cause_r <= '0;
        end else if (int_req) begin
            irq_pend_r <= 1'b1;
            cause_r <= int_cause;
        end else if (st_r == S_IDLE && strobe && my_iack) begin
            irq_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iack_own_r <= 1'b0;
            iackout_n_r <= 1'b1;
        end else begin
            if (st_r == S_IDLE && strobe && my_iack) begin
                iack_own_r <= 1'b1;
            end else if (as_n_s) begin
                iack_own_r <= 1'b0;
            end
            iackout_n_r <= !(!iack_n_s && !iackin_n_s && !as_n_s && !my_iack && !iack_own_r);
        end
    end

    // Response path; a line feed with END closes every message
    assign f_in_valid = lf_pend_r || rsp_valid;
    assign f_in_data = lf_pend_r ? {1'b1, LF_CHAR} : {1'b0, rsp_byte};
    assign rsp_ready = f_in_ready && !lf_pend_r;

    always_ff @(posedge sys_clk) begin
        if (rst || clr_all) begin
            lf_pend_r <= 1'b0;
        end else if (lf_pend_r) begin
            lf_pend_r <= !f_in_ready;
        end else if (rsp_valid && rsp_ready && rsp_last) begin
            lf_pend_r <= 1'b1;
        end
    end

    resp_fifo #(.W(RSP_W), .DEPTH(RSP_DEPTH)) u_rsp (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(clr_all),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data)
    );

    // Command input ring, entries {term, sep, ws, byte}
    assign term_in = d_s[END_POS] || d_s[7:0] == LF_CHAR;
    assign ws_in = d_s[7:0] <= SPACE_CHAR && d_s[7:0] != LF_CHAR;
    assign sep_in = d_s[7:0] == SEMI_CHAR;
    assign up_in = (d_s[7:0] >= LOW_A && d_s[7:0] <= LOW_Z) ? (d_s[7:0] & CASE_MASK)
        : d_s[7:0];
    assign str_full = str_cnt_r == MAX_STRINGS;
    assign q_full = str_full || ring_cnt_r >= RING_DEPTH - 9'h1;
    // A terminator may use the last slot so a truncated string still closes
    assign push = bav && !drop_r && !(cur_len_r == 8'h00 && str_full)
        && (term_in ? ring_cnt_r != RING_DEPTH
            : (ring_cnt_r < RING_DEPTH - 9'h1 && cur_len_r != MAX_STR_LEN));

    assign head = ring_r[rp_r];
    assign avail = str_cnt_r != 5'h00;
    assign skip = avail && head[8] && lead_r && !head[10];
    assign cmd_valid = avail && !skip;
    assign pop = skip || (cmd_valid && cmd_ready);
    assign cmd_byte = head[7:0];
    assign cmd_ws = head[8];
    assign cmd_sep = head[9];
    assign cmd_last = head[10];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            ring_r[wp_r] <= {term_in, sep_in, ws_in, ws_in ? SPACE_CHAR : up_in};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || clr_all) begin
            wp_r <= '0;
            rp_r <= '0;
            ring_cnt_r <= '0;
            str_cnt_r <= '0;
            cur_len_r <= '0;
            drop_r <= 1'b0;
            lead_r <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 8'h01;
                cur_len_r <= term_in ? 8'h00 : cur_len_r + 8'h01;
            end
            if (bav && !push && cur_len_r == 8'h00 && str_full) begin
                drop_r <= !term_in;
            end else if (bav && drop_r && term_in) begin
                drop_r <= 1'b0;
            end
            if (pop) begin
                rp_r <= rp_r + 8'h01;
                lead_r <= head[10] || head[9] || head[8];
            end
            ring_cnt_r <= ring_cnt_r + {8'h00, push} - {8'h00, pop};
            str_cnt_r <= str_cnt_r + {4'h0, push && term_in} - {4'h0, pop && head[10]};
        end
    end

    AST_BERR_AFTER_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(bus_berr_oe) |-> $past(st_r) == S_WAIT && $past(brq_pend_r))
        else $error("Bus error without a stalled fast read");
    AST_FHS_BOUND: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == S_WAIT && !rr_r && !ds_idle) |-> ##[1:13] st_r != S_WAIT)
        else $error("Fast read stalled beyond its window");
    AST_PROTO_READ: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == S_IDLE && strobe && hit && wr_n_s && off == OFF_PROTO)
        |=> bus_dtack_oe && bus_data_oe && bus_data_o == PROTO_VAL)
        else $error("Protocol register read wrong");
    AST_RDPROTO: assert property (@(posedge sys_clk) disable iff (rst)
        (rdp && !rr_r && !clr_all && !dlo_rd_take) |=> rr_r && data_low_r == RDPROTO_VAL)
        else $error("Read-protocol answer missing");
    AST_DIR_FULL: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == S_IDLE && strobe && hit && wr_n_s && off == OFF_RESP && str_full)
        |=> !bus_data_o[RB_DIR])
        else $error("Data-in-ready set while queue full");
    AST_HOLD_TILL_TERM: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_valid |-> str_cnt_r != 5'h00)
        else $error("Command byte released before terminator");
    AST_NO_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
        (st_r == S_IDLE && strobe && hit && wr_n_s && off == OFF_DLO && !rr_r && !brq_pend_r)
        |=> (!bus_dtack_oe && !bus_berr_oe) [*3])
        else $error("Read answered with no query pending");
    AST_UPPER: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_valid |-> !(cmd_byte >= LOW_A && cmd_byte <= LOW_Z))
        else $error("Lower-case letter passed to processor");
    AST_WS_SPACE: assert property (@(posedge sys_clk) disable iff (rst)
        (cmd_valid && cmd_ws) |-> cmd_byte == SPACE_CHAR && !$past(cmd_ws && pop))
        else $error("White space not collapsed");
    AST_LF_TAIL: assert property (@(posedge sys_clk) disable iff (rst)
        (rsp_valid && rsp_ready && rsp_last && !clr_all) |=> lf_pend_r && !rsp_ready)
        else $error("Response not closed by line feed");
endmodule

// file: verif/wss_commander.sv
// Purpose: Backplane commander model issuing A16/D16 slave cycles
// Assumes: One cycle at a time; answer taken on the edge it is seen
// Notes: Released data pins show the inverse of the last word
module wss_commander (
    // Clock and returns
    input wire logic sys_clk,
    input wire logic [15:0] pins,
    input wire logic dtack_oe,
    input wire logic berr_oe,
    // Strobes and data
    output logic [15:1] addr = '0,
    output logic [5:0] am = wss_pkg::AM_A16_USER,
    output logic as_n = 1'b1,
    output logic [1:0] ds_n = 2'h3,
    output logic write_n = 1'b1,
    output logic lword_n = 1'b1,
    output logic iack_n = 1'b1,
    output logic iackin_n = 1'b1,
    output logic [15:0] dout = 16'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Set by the bench between cycles to run an interrupt acknowledge
    logic iack_mode = 1'b0;
    task automatic cycle(input logic wr, input logic [15:0] a, input logic [15:0] wd,
        output logic [15:0] rd, output int st);
        int n;
        st = 2;
        rd = 16'h0;
        @(posedge sys_clk);
        addr <= a[15:1];
        write_n <= ~wr;
        dout <= wd;
        as_n <= 1'b0;
        ds_n <= 2'h0;
        iack_n <= ~iack_mode;
        iackin_n <= ~iack_mode;
        // Level seen at the falling edge is what the next rising edge samples
        for (n = 0; n < 40 && st == 2; n++) begin
            @(negedge sys_clk);
            if (dtack_oe) begin
                st = 0;
                rd = pins;
            end else if (berr_oe) begin
                st = 1;
            end
        end
        @(posedge sys_clk);
        as_n <= 1'b1;
        ds_n <= 2'h3;
        write_n <= 1'b1;
        iack_n <= 1'b1;
        iackin_n <= 1'b1;
        dout <= ~wd;
        for (n = 0; n < 8 && (dtack_oe || berr_oe); n++) @(negedge sys_clk);
    endtask
endmodule

// file: verif/word_serial_servant_port_tb.sv
// Purpose: Self-checking bench for the word-serial servant port
// Assumes: Commander model drives the backplane, bench plays processor
// Notes: Status 2 from a cycle means no answer before timeout
module word_serial_servant_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wss_pkg::*;
    localparam logic [7:0] LA = 8'h05;
    localparam logic [15:0] BASE = 16'hc000 + {8'h0, LA} * 16'h0040;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_ready = 1'b1;
    logic [7:0] rsp_byte = 8'h0;
    logic rsp_last = 1'b0;
    logic rsp_valid = 1'b0;
    logic int_req = 1'b0;
    logic [7:0] int_cause = 8'h0;
    logic irqoe;
    logic [15:1] addr;
    logic [5:0] am;
    logic as_n, write_n, lword_n, iack_n, iackin_n, ddoe, dtoe, beoe, rsp_ready;
    logic [1:0] ds_n;
    logic [15:0] cdata, ddata, pins, rd;
    logic [7:0] cmd_byte;
    logic cmd_sep, cmd_ws, cmd_last, cmd_valid;
    int err_total = 0;
    int n_compared = 0;
    int st, i, n;
    logic [10:0] got[$];
    logic [7:0] txt[5] = '{8'h61, 8'h20, 8'h3b, 8'h42, 8'h0a};
    logic [10:0] exp_c[5] = '{11'h041, 11'h220, 11'h13b, 11'h042, 11'h40a};
    assign pins = ddoe ? ddata : cdata;
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    wss_commander u_cmdr (.sys_clk(sys_clk), .pins(pins), .dtack_oe(dtoe), .berr_oe(beoe),
        .addr(addr), .am(am), .as_n(as_n), .ds_n(ds_n), .write_n(write_n),
        .lword_n(lword_n), .iack_n(iack_n), .iackin_n(iackin_n), .dout(cdata));
    word_serial_servant_port u_dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(addr),
        .bus_am(am), .bus_as_n(as_n), .bus_ds_n(ds_n), .bus_write_n(write_n),
        .bus_lword_n(lword_n), .bus_iack_n(iack_n), .bus_iackin_n(iackin_n),
        .bus_iackout_n(), .bus_data_i(pins), .bus_data_o(ddata), .bus_data_oe(ddoe),
        .bus_dtack_o(), .bus_dtack_oe(dtoe), .bus_berr_o(), .bus_berr_oe(beoe),
        .bus_irq_o(), .bus_irq_oe(irqoe), .la_switch(LA), .cmd_byte(cmd_byte),
        .cmd_sep(cmd_sep), .cmd_ws(cmd_ws), .cmd_last(cmd_last), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .int_req(int_req),
        .int_cause(int_cause), .iface_clear());
    always @(negedge sys_clk) begin
        if (cmd_valid && cmd_ready) begin
            got.push_back({cmd_last, cmd_ws, cmd_sep, cmd_byte});
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic wr, input logic [5:0] off, input logic [15:0] wd);
        u_cmdr.cycle(wr, BASE + {10'h0, off}, wd, rd, st);
    endtask
    task automatic poll(input logic [15:0] m);
        for (int k = 0; k < 30; k++) begin
            acc(1'b0, OFF_RESP, 16'h0);
            if ((rd & m) === m) break;
        end
        chk(rd & m, m);
    endtask
    task automatic nread(input logic [15:0] e);
        poll(16'h2200);
        acc(1'b1, OFF_DLO, BRQ_WORD);
        poll(16'h2400);
        acc(1'b0, OFF_DLO, 16'h0);
        chk(rd, e);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        acc(1'b0, OFF_PROTO, 16'h0);
        chk(rd, PROTO_VAL);
        acc(1'b0, OFF_STAT, 16'h0);
        chk(rd, 16'hffff);
        acc(1'b0, OFF_RESP, 16'h0);
        chk(rd, 16'h5bff);
        acc(1'b0, 6'h10, 16'h0);
        chk(16'(st), 16'h2);
        u_cmdr.cycle(1'b0, BASE + 16'h0040, 16'h0, rd, st);
        chk(16'(st), 16'h2);
        acc(1'b0, OFF_DLO, 16'h0);
        chk(16'(st), 16'h2);
        for (i = 0; i < 5; i++) begin
            poll(16'h1200);
            acc(1'b1, OFF_DLO, {BAV_TAG, 1'b0, txt[i]});
            if (i == 3) chk(16'(got.size()), 16'h0);
        end
        repeat (10) @(posedge sys_clk);
        chk(16'(got.size()), 16'h5);
        for (i = 0; i < 5; i++) chk({5'h0, got[i]}, {5'h0, exp_c[i]});
        @(posedge sys_clk);
        rsp_valid <= 1'b1;
        rsp_byte <= 8'h58;
        rsp_last <= 1'b1;
        @(posedge sys_clk);
        rsp_valid <= 1'b0;
        rsp_last <= 1'b0;
        nread(16'h0058);
        nread(16'h010a);
        acc(1'b1, OFF_DLO, BRQ_WORD);
        acc(1'b0, OFF_DLO, 16'h0);
        chk(16'(st), 16'h1);
        // Fill the response buffer with no reader until it refuses
        @(posedge sys_clk);
        rsp_valid <= 1'b1;
        rsp_byte <= 8'h30;
        n = 0;
        repeat (30) begin
            @(negedge sys_clk);
            if (rsp_ready) n++;
            @(posedge sys_clk);
            rsp_byte <= 8'h30 + 8'(n);
        end
        rsp_valid <= 1'b0;
        chk(16'(n >= 16 && n < 30), 16'h1);
        poll(16'h2400);
        acc(1'b0, OFF_DLO, 16'h0);
        chk(rd, 16'h0030);
        for (i = 1; i < n; i++) nread(16'h0030 + 16'(i));
        acc(1'b0, OFF_RESP, 16'h0);
        chk(rd, 16'h5bff);
        acc(1'b1, OFF_DLO, 16'hcfff);
        poll(16'h2400);
        acc(1'b0, OFF_DLO, 16'h0);
        chk(rd, RDPROTO_VAL);
        // A pending byte request holds write-ready low until Clear drops it
        acc(1'b1, OFF_DLO, BRQ_WORD);
        acc(1'b1, OFF_DLO, 16'hffff);
        acc(1'b0, OFF_RESP, 16'h0);
        chk(rd, 16'h5bff);
        @(posedge sys_clk);
        int_cause <= 8'h5a;
        int_req <= 1'b1;
        @(posedge sys_clk);
        int_req <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0, irqoe}, 16'h1);
        u_cmdr.iack_mode = 1'b1;
        u_cmdr.cycle(1'b0, 16'h0002, 16'h0, rd, st);
        u_cmdr.iack_mode = 1'b0;
        chk(rd, {8'h5a, LA});
        chk({15'h0, irqoe}, 16'h0);
        report_and_stop();
    end
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
endmodule
